// File: rtl/vtp_vlan_tag_port_handler.sv
// Purpose: per-port 802.1Q tag decisions, vlan group table and management access gate
// Assumes: one clock, synchronous active-high reset, AHB-Lite single-word register access
// Notes:   one frame decision at a time; the table is scanned one entry per cycle
//
// Operation
// - with 802.1Q on, every port starts in default VLAN 1
// - only VIDs 1 to 4094 are accepted for untagged and tagged settings
// - table holds up to 256 groups; default group cannot be removed
// - untagged frame entering an access port gets a four-byte tag
// - the inserted tag carries the ingress port's untagged VID in its 12 bits
// - tagged frame leaving an access port with matching VID is stripped
// - access ports sharing an untagged VID form one forwarding group
// - trunk port never tags untagged frames it receives and has no untagged VID
// - trunk forwards tagged frames only for VIDs on its tagged list
// - trunk always forwards VLAN 1 frames
// - hybrid port carries both tagged and untagged frames
// - hybrid uses its untagged VID like access, plus its tagged list
// - hybrid always forwards VLAN 1 frames
// - nonzero management VID admits only ports whose untagged VID matches
// - management VID resets to 0, which admits every VLAN
// - untagged VID used on access/hybrid only; tagged list on trunk/hybrid only
// - GVRP enable acts only while the mode is 802.1Q
// - mode resets to disabled; no tagging or filtering then
`timescale 1ns/1ps
`include "vtp_map.svh"
`default_nettype none

module vtp_vlan_tag_port_handler
   import vtp_pkg::*;
(
   input  wire logic        CLK_SYS,
   input  wire logic        SYS_RST,
   input  wire logic        CE,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic        REQ_VALID,
   output logic             REQ_READY,
   input  wire logic [4:0]  REQ_IN_PORT,
   input  wire logic [4:0]  REQ_OUT_PORT,
   input  wire logic        REQ_TAGGED,
   input  wire logic [11:0] REQ_VID,
   output logic             RES_VALID,
   output logic             RES_FWD,
   output logic             RES_ING_TAG,
   output logic             RES_INSERT,
   output logic             RES_STRIP,
   output logic      [11:0] RES_VID,
   input  wire logic [4:0]  MGMT_PORT,
   output logic             MGMT_GRANT,
   output logic             GVRP_ACTIVE
);

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   vtp_mode_type        mode_ff;
   logic                gvrp_ff;
   logic         [11:0] mgmt_vid_ff;
   logic                rej_ff;
   logic          [7:0] tidx_ff;
   logic          [8:0] grp_cnt_ff;
   vtp_link_type        link_ff    [`VTP_NUM_PORTS];
   logic         [11:0] pvid_ff    [`VTP_NUM_PORTS];
   logic         [11:0] tbl_vid_ff [`VTP_NUM_GROUPS];
   logic                tbl_val_ff [`VTP_NUM_GROUPS];
   logic         [25:0] tbl_mem_ff [`VTP_NUM_GROUPS];
   logic                dp_wr_ff;
   logic         [11:0] dp_addr_ff;
   logic         [31:0] rdata_ff;
   logic         [31:0] nxt_rdata;
   vtp_state_type       state_ff;
   logic          [7:0] scan_ff;
   logic                hit_ff;
   logic                bad_ff;
   logic                in_tag_ff;
   logic                ing_ins_ff;
   logic         [11:0] fvid_ff;
   logic          [4:0] out_ff;
   logic                res_valid_ff;
   logic                res_fwd_ff;
   logic                res_ins_ff;
   logic                res_strip_ff;
   logic         [11:0] res_vid_ff;
   logic                res_q_ff;
   logic                grant_ff;
   logic                gvrp_act_ff;

   function automatic logic vid_ok(input logic [11:0] v);
      vid_ok = (v >= `VTP_VID_MIN) && (v <= `VTP_VID_MAX);
   endfunction

   // ------------------------------------------------------------------
   // ahb-lite slave: zero wait states while enabled
   // ------------------------------------------------------------------
   logic ahb_go;
   logic wr_en;
   logic rej_now;
   logic set_rej;
   logic clr_rej;
   logic port_w;
   logic [4:0] port_wi;
   logic [4:0] port_ri;
   logic [11:0] w_vid;
   logic [11:0] w_pvid;
   logic [1:0] w_link;
   logic dq;

   assign ahb_go    = HSEL && HTRANS[1] && HREADY && CE;
   assign HREADYOUT = CE;              // a frozen block stretches the data phase
   assign HRESP     = 1'b0;
   assign HRDATA    = rdata_ff;
   assign wr_en     = dp_wr_ff && CE;
   assign port_wi   = dp_addr_ff[6:2];
   assign port_w    = (dp_addr_ff[11:8] == `VTP_PORT_PAGE) && !dp_addr_ff[7] && (port_wi <= `VTP_PORT_LAST);
   assign port_ri   = HADDR[6:2];
   assign w_vid     = HWDATA[11:0];
   assign w_pvid    = HWDATA[`VTP_PCFG_VID_LSB +: 12];
   assign w_link    = HWDATA[1:0];
   assign dq        = (mode_ff == VTP_MODE_DOT1Q);

   // address phase capture
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         dp_wr_ff   <= 1'b0;
         dp_addr_ff <= 12'h000;
      end else if (CE) begin
         dp_wr_ff   <= ahb_go && HWRITE;
         dp_addr_ff <= HADDR[11:0];
      end
   end

   // read mux, sampled at the address phase so hrdata comes from a flop
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (HADDR[11:8] == `VTP_PORT_PAGE) begin
         if (!HADDR[7] && (port_ri <= `VTP_PORT_LAST))
            nxt_rdata = {4'h0, pvid_ff[port_ri], 14'h0000, link_ff[port_ri]};
      end else begin
         case (HADDR[11:0])
            `VTP_OFF_CTRL:  nxt_rdata = {29'h0, gvrp_ff, mode_ff};
            `VTP_OFF_MGMT:  nxt_rdata = {20'h0, mgmt_vid_ff};
            `VTP_OFF_STAT:  nxt_rdata = {15'h0, rej_ff, 7'h00, grp_cnt_ff};
            `VTP_OFF_TIDX:  nxt_rdata = {24'h0, tidx_ff};
            `VTP_OFF_TVID:  nxt_rdata = {16'h0, tbl_val_ff[tidx_ff], 3'h0, tbl_vid_ff[tidx_ff]};
            `VTP_OFF_TMEMB: nxt_rdata = {6'h00, tbl_mem_ff[tidx_ff]};
            default:        nxt_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST)
         rdata_ff <= 32'h0000_0000;
      else if (ahb_go && !HWRITE)
         rdata_ff <= nxt_rdata;
   end

   // ------------------------------------------------------------------
   // global configuration
   // ------------------------------------------------------------------
   // mode and gvrp enable; mode reset keeps tagging and filtering off
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         mode_ff <= VTP_MODE_OFF;
         gvrp_ff <= 1'b0;
         tidx_ff <= 8'h00;
      end else if (wr_en && !port_w) begin
         if (dp_addr_ff == `VTP_OFF_CTRL) begin
            mode_ff <= vtp_mode_type'(HWDATA[1:0]);
            gvrp_ff <= HWDATA[`VTP_CTRL_GVRP_BIT];
         end
         if (dp_addr_ff == `VTP_OFF_TIDX)
            tidx_ff <= HWDATA[7:0];
      end
   end

   // management vid: 0 opens access to all, 4095 is refused
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST)
         mgmt_vid_ff <= `VTP_MGMT_VID_RST;
      else if (wr_en && !port_w && (dp_addr_ff == `VTP_OFF_MGMT) && (w_vid <= `VTP_VID_MAX))
         mgmt_vid_ff <= w_vid;
   end

   // rejected-write flag: write one to clear, a new rejection wins
   always_comb begin
      rej_now = 1'b0;
      if (wr_en && port_w)
         rej_now = (w_link == VTP_LINK_RSVD) || !vid_ok(w_pvid);
      else if (wr_en && (dp_addr_ff == `VTP_OFF_MGMT))
         rej_now = (w_vid > `VTP_VID_MAX);
      else if (wr_en && (dp_addr_ff == `VTP_OFF_TVID))
         rej_now = (tidx_ff == 8'h00) || (HWDATA[`VTP_TVID_VAL_BIT] && !vid_ok(w_vid));
   end
   assign set_rej = rej_now;
   assign clr_rej = wr_en && !port_w && (dp_addr_ff == `VTP_OFF_STAT) && HWDATA[`VTP_STAT_REJ_BIT];

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST)
         rej_ff <= 1'b0;
      else if (CE)
         rej_ff <= set_rej || (rej_ff && !clr_rej);
   end

   // ------------------------------------------------------------------
   // per-port link type and untagged vid
   // ------------------------------------------------------------------
   // every port comes up as an access port of the default vlan
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         for (int p = 0; p < `VTP_NUM_PORTS; p++) begin
            link_ff[p] <= VTP_LINK_ACCESS;
            pvid_ff[p] <= `VTP_DEFAULT_VID;
         end
      end else if (wr_en && port_w && !rej_now) begin
         link_ff[port_wi] <= vtp_link_type'(w_link);
         pvid_ff[port_wi] <= w_pvid;
      end
   end

   // ------------------------------------------------------------------
   // vlan group table: entry 0 is the fixed default group
   // ------------------------------------------------------------------
   logic tbl_vid_w;
   logic tbl_mem_w;
   assign tbl_vid_w = wr_en && !port_w && (dp_addr_ff == `VTP_OFF_TVID) && !rej_now;
   assign tbl_mem_w = wr_en && !port_w && (dp_addr_ff == `VTP_OFF_TMEMB);

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         for (int g = 0; g < `VTP_NUM_GROUPS; g++) begin
            tbl_vid_ff[g] <= 12'h000;
            tbl_val_ff[g] <= 1'b0;
            tbl_mem_ff[g] <= 26'h0000000;
         end
         tbl_vid_ff[0] <= `VTP_DEFAULT_VID;
         tbl_val_ff[0] <= 1'b1;
         tbl_mem_ff[0] <= `VTP_ALL_PORTS;
      end else begin
         if (tbl_vid_w) begin
            tbl_vid_ff[tidx_ff] <= w_vid;
            tbl_val_ff[tidx_ff] <= HWDATA[`VTP_TVID_VAL_BIT];
         end
         if (tbl_mem_w)
            tbl_mem_ff[tidx_ff] <= HWDATA[25:0];
      end
   end

   // live group count, never below one because entry 0 stays
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST)
         grp_cnt_ff <= 9'h001;
      else if (tbl_vid_w && (HWDATA[`VTP_TVID_VAL_BIT] != tbl_val_ff[tidx_ff]))
         grp_cnt_ff <= HWDATA[`VTP_TVID_VAL_BIT] ? grp_cnt_ff + 9'h001 : grp_cnt_ff - 9'h001;
   end

   // ------------------------------------------------------------------
   // frame engine: classify, scan table, decide
   // ------------------------------------------------------------------
   vtp_link_type in_link;
   vtp_link_type e_link;
   logic [11:0]  e_pvid;
   logic [11:0]  cls_vid;
   logic         in_bad;
   logic         tbl_hit;
   logic         d_fwd;
   logic         d_otag;

   assign REQ_READY = (state_ff == VTP_ST_IDLE) && CE;
   assign in_bad    = (REQ_IN_PORT > `VTP_PORT_LAST) || (REQ_OUT_PORT > `VTP_PORT_LAST);
   assign in_link   = in_bad ? VTP_LINK_RSVD : link_ff[REQ_IN_PORT];
   // trunks add no tag, so untagged trunk traffic rides the default vlan
   assign cls_vid   = REQ_TAGGED ? REQ_VID :
                      ((in_link == VTP_LINK_TRUNK) || in_bad) ? `VTP_DEFAULT_VID : pvid_ff[REQ_IN_PORT];
   assign tbl_hit   = tbl_val_ff[scan_ff] && (tbl_vid_ff[scan_ff] == fvid_ff) && tbl_mem_ff[scan_ff][out_ff];
   assign e_link    = bad_ff ? VTP_LINK_RSVD : link_ff[out_ff];
   assign e_pvid    = bad_ff ? 12'h000 : pvid_ff[out_ff];

   // state and scan pointer; the scan stops at the first matching entry
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         state_ff <= VTP_ST_IDLE;
         scan_ff  <= 8'h00;
         hit_ff   <= 1'b0;
      end else if (CE) begin
         case (state_ff)
            VTP_ST_IDLE: begin
               scan_ff <= 8'h00;
               hit_ff  <= 1'b0;
               if (REQ_VALID)
                  state_ff <= dq ? VTP_ST_SCAN : VTP_ST_DONE;
            end
            VTP_ST_SCAN: begin
               if (tbl_hit) begin
                  hit_ff   <= 1'b1;
                  state_ff <= VTP_ST_DONE;
               end else if (scan_ff == `VTP_GROUP_LAST) begin
                  state_ff <= VTP_ST_DONE;
               end else begin
                  scan_ff <= scan_ff + 8'h01;
               end
            end
            VTP_ST_DONE: state_ff <= VTP_ST_IDLE;
            default:     state_ff <= VTP_ST_IDLE;
         endcase
      end
   end

   // request capture
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         in_tag_ff  <= 1'b0;
         ing_ins_ff <= 1'b0;
         fvid_ff    <= 12'h000;
         out_ff     <= 5'h00;
         bad_ff     <= 1'b0;
      end else if (REQ_READY && REQ_VALID) begin
         in_tag_ff  <= REQ_TAGGED;
         ing_ins_ff <= dq && !REQ_TAGGED && !in_bad && (in_link != VTP_LINK_TRUNK);
         fvid_ff    <= cls_vid;
         out_ff     <= REQ_OUT_PORT;
         bad_ff     <= in_bad;
      end
   end

   // egress decision; untagged vid only counts on access and hybrid ports
   always_comb begin
      d_fwd  = 1'b0;
      d_otag = in_tag_ff;
      if (!dq) begin
         d_fwd  = 1'b1;
      end else if (!vid_ok(fvid_ff) || bad_ff) begin
         d_fwd  = 1'b0;
      end else begin
         case (e_link)
            VTP_LINK_ACCESS: begin
               d_fwd  = (fvid_ff == e_pvid);
               d_otag = 1'b0;
            end
            VTP_LINK_TRUNK: begin
               d_fwd  = (fvid_ff == `VTP_DEFAULT_VID) || hit_ff;
               d_otag = (fvid_ff != `VTP_DEFAULT_VID) || in_tag_ff;
            end
            VTP_LINK_HYBRID: begin
               if (fvid_ff == e_pvid) begin
                  d_fwd  = 1'b1;
                  d_otag = 1'b0;
               end else begin
                  d_fwd  = (fvid_ff == `VTP_DEFAULT_VID) || hit_ff;
                  d_otag = (fvid_ff != `VTP_DEFAULT_VID) || in_tag_ff;
               end
            end
            default: d_fwd = 1'b0;
         endcase
      end
   end

   // result register, one-cycle valid pulse
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         res_valid_ff <= 1'b0;
         res_fwd_ff   <= 1'b0;
         res_ins_ff   <= 1'b0;
         res_strip_ff <= 1'b0;
         res_vid_ff   <= 12'h000;
         res_q_ff     <= 1'b0;
      end else if (CE) begin
         res_valid_ff <= (state_ff == VTP_ST_DONE);
         if (state_ff == VTP_ST_DONE) begin
            res_fwd_ff   <= d_fwd;
            res_ins_ff   <= d_fwd && d_otag && !in_tag_ff;
            res_strip_ff <= d_fwd && !d_otag && in_tag_ff;
            res_vid_ff   <= fvid_ff;
            res_q_ff     <= dq;
         end
      end
   end

   assign RES_VALID   = res_valid_ff;
   assign RES_FWD     = res_fwd_ff;
   assign RES_ING_TAG = ing_ins_ff;
   assign RES_INSERT  = res_ins_ff;
   assign RES_STRIP   = res_strip_ff;
   assign RES_VID     = res_vid_ff;

   // ------------------------------------------------------------------
   // management gate and gvrp
   // ------------------------------------------------------------------
   // a trunk has no untagged vid, so it never matches a nonzero value
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         grant_ff    <= 1'b1;
         gvrp_act_ff <= 1'b0;
      end else if (CE) begin
         grant_ff    <= (mgmt_vid_ff == 12'h000) ||
                        ((MGMT_PORT <= `VTP_PORT_LAST) && (link_ff[MGMT_PORT] != VTP_LINK_TRUNK) &&
                         (pvid_ff[MGMT_PORT] == mgmt_vid_ff));
         gvrp_act_ff <= gvrp_ff && dq;
      end
   end
   assign MGMT_GRANT  = grant_ff;
   assign GVRP_ACTIVE = gvrp_act_ff;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);

   a_reset_values: assert property ($past(SYS_RST) |-> mode_ff == VTP_MODE_OFF && mgmt_vid_ff == 12'h000)
      else $error("mode or management vid not at reset value");
   a_mgmt_open: assert property (CE && mgmt_vid_ff == 12'h000 |=> MGMT_GRANT)
      else $error("management refused while limit is off");
   a_mgmt_trunk: assert property (CE && mgmt_vid_ff != 12'h000 && MGMT_PORT <= 5'h19 &&
                                  link_ff[MGMT_PORT] == VTP_LINK_TRUNK |=> !MGMT_GRANT)
      else $error("management granted to a trunk port");
   a_group_count: assert property (grp_cnt_ff >= 9'h001 && grp_cnt_ff <= 9'h100 && tbl_val_ff[0] &&
                                   tbl_vid_ff[0] == 12'h001)
      else $error("group table lost its default entry");
   a_access_ins: assert property (REQ_READY && REQ_VALID && dq && !REQ_TAGGED && !in_bad &&
                                  in_link == VTP_LINK_ACCESS |=> ing_ins_ff && fvid_ff == $past(cls_vid))
      else $error("access ingress did not tag with port vid");
   a_trunk_noins: assert property (REQ_READY && REQ_VALID && in_link == VTP_LINK_TRUNK |=> !ing_ins_ff)
      else $error("trunk ingress inserted a tag");
   a_access_strip: assert property (CE && state_ff == VTP_ST_DONE && dq && e_link == VTP_LINK_ACCESS &&
                                    in_tag_ff && vid_ok(fvid_ff) && fvid_ff == e_pvid
                                    |=> RES_VALID && RES_FWD && RES_STRIP)
      else $error("matching access egress kept the tag");
   a_trunk_vlan1: assert property (CE && state_ff == VTP_ST_DONE && dq && !bad_ff && e_link == VTP_LINK_TRUNK &&
                                   fvid_ff == 12'h001 |=> RES_VALID && RES_FWD)
      else $error("trunk dropped a vlan 1 frame");
   a_vid_range: assert property (RES_VALID && RES_FWD && res_q_ff |-> RES_VID >= 12'h001 && RES_VID <= 12'hFFE)
      else $error("frame forwarded with an illegal vid");
   a_gvrp_gate: assert property (CE && mode_ff != VTP_MODE_DOT1Q |=> !GVRP_ACTIVE)
      else $error("gvrp active outside 802.1Q mode");

endmodule

`default_nettype wire

// File: rtl/vtp_map.svh
// Purpose: offsets, field positions, reset values and sizes of the vlan tag port handler
// Assumes: included by bare name from the design
// Notes:   definitions only
`ifndef VTP_MAP_SVH
`define VTP_MAP_SVH

// ------------------------------------------------------------------
// sizes and vlan identifiers
// ------------------------------------------------------------------
`define VTP_NUM_PORTS      26
`define VTP_PORT_LAST      5'h19
`define VTP_NUM_GROUPS     256
`define VTP_GROUP_LAST     8'hFF
`define VTP_VID_MIN        12'h001
`define VTP_VID_MAX        12'hFFE
`define VTP_DEFAULT_VID    12'h001
`define VTP_MGMT_VID_RST   12'h000
`define VTP_ALL_PORTS      26'h3FFFFFF

// ------------------------------------------------------------------
// register byte offsets (address bits 11:0)
// ------------------------------------------------------------------
`define VTP_OFF_CTRL       12'h000
`define VTP_OFF_MGMT       12'h004
`define VTP_OFF_STAT       12'h008
`define VTP_OFF_TIDX       12'h00C
`define VTP_OFF_TVID       12'h010
`define VTP_OFF_TMEMB      12'h014
`define VTP_PORT_PAGE      4'h1

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define VTP_CTRL_GVRP_BIT  2
`define VTP_STAT_REJ_BIT   16
`define VTP_TVID_VAL_BIT   15
`define VTP_PCFG_VID_LSB   16

`endif

// File: rtl/vtp_pkg.sv
// Purpose: types shared by the vlan tag port handler
// Assumes: constants live in vtp_map.svh
// Notes:   enum order gives the encodings written by software
package vtp_pkg;
   typedef enum logic [1:0] {VTP_LINK_ACCESS, VTP_LINK_TRUNK, VTP_LINK_HYBRID, VTP_LINK_RSVD} vtp_link_type;
   typedef enum logic [1:0] {VTP_MODE_OFF, VTP_MODE_PORT, VTP_MODE_DOT1Q, VTP_MODE_RSVD} vtp_mode_type;
   typedef enum logic [1:0] {VTP_ST_IDLE, VTP_ST_SCAN, VTP_ST_DONE} vtp_state_type;
endpackage

// File: verification/vtp_station.sv
// Purpose: far-side station that presents frame requests
// Assumes: one request outstanding at a time
// Notes:   fields toggle once taken, so stale values never look valid
`timescale 1ns/1ps
`default_nettype none
module vtp_station (
   input  wire logic        CLK_SYS,
   input  wire logic        RST,
   input  wire logic        SEND,
   input  wire logic [22:0] FIELDS,
   input  wire logic        REQ_READY,
   output logic             REQ_VALID,
   output logic      [22:0] REQ_BITS
);
   // hold the request until taken, then drive a changing pattern
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         REQ_VALID <= 1'b0;
         REQ_BITS  <= 23'h0;
      end else if (SEND) begin
         REQ_VALID <= 1'b1;
         REQ_BITS  <= FIELDS;
      end else if (REQ_VALID && REQ_READY) begin
         REQ_VALID <= 1'b0;
      end else if (!REQ_VALID) begin
         REQ_BITS  <= ~REQ_BITS;
      end
   end
endmodule
`default_nettype wire

// File: verification/test_vtp_vlan_tag_port_handler.sv
// Purpose: self-checking bench for the vlan tag port handler
// Assumes: CE held high, one slave on the bus
// Notes:   expected decisions come from a small model of the port tables
`timescale 1ns/1ps
`default_nettype none
module test_vtp_vlan_tag_port_handler;
   logic        clk = 0, rst = 1, hsel = 0, hwrite = 0, send = 0;
   logic [31:0] haddr = 0, hwdata = 0;
   logic [1:0]  htrans = 0;
   logic [22:0] fields = 0;
   logic [4:0]  mport = 0;
   wire         hready, hresp, rdy, vld, res_v, fwd, ing, ins, strp, grant, gvrp;
   wire  [31:0] hrdata;
   wire  [11:0] rvid;
   wire  [22:0] rb;
   int          fails = 0, n_compared = 0, md = 0, k, vals[5] = '{1, 20, 30, 40, 4095};
   int          lnk[5] = '{0, 0, 1, 2, 0}, pv[5] = '{1, 1, 1, 20, 20};
   vtp_vlan_tag_port_handler dut_u (.CLK_SYS(clk), .SYS_RST(rst), .CE(1'b1), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
      .HREADYOUT(hready), .HRESP(hresp), .REQ_VALID(vld), .REQ_READY(rdy), .REQ_IN_PORT(rb[22:18]),
      .REQ_OUT_PORT(rb[17:13]), .REQ_TAGGED(rb[12]), .REQ_VID(rb[11:0]), .RES_VALID(res_v), .RES_FWD(fwd),
      .RES_ING_TAG(ing), .RES_INSERT(ins), .RES_STRIP(strp), .RES_VID(rvid), .MGMT_PORT(mport),
      .MGMT_GRANT(grant), .GVRP_ACTIVE(gvrp));
   vtp_station st_u (.CLK_SYS(clk), .RST(rst), .SEND(send), .FIELDS(fields), .REQ_READY(rdy),
      .REQ_VALID(vld), .REQ_BITS(rb));
   always #5 clk = ~clk;
   // ------------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one single transfer; an idle cycle after it keeps reads off a fresh write
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= a;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      r = hrdata;
      chk(hresp, 1'b0);
      @(posedge clk);
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask
   // send one frame and compare the decision with the model
   task automatic frame(input int i, input int o, input int t, input int v);
      int ev, ok, ot, n;
      send <= 1'b1; fields <= {i[4:0], o[4:0], t[0], v[11:0]};
      @(posedge clk);
      send <= 1'b0;
      // look mid-cycle so the one-cycle pulse is seen settled, not at its launching edge
      for (n = 0; n < 400 && res_v !== 1'b1; n++) @(negedge clk);
      chk(res_v, 1'b1);
      if (md != 2) begin
         chk(fwd, 1);
         chk({ins, strp, ing}, 0);
      end else begin
         ev = t ? v : (lnk[i] == 1 ? 1 : pv[i]);
         ok = (lnk[o] != 1 && ev == pv[o]) || (lnk[o] != 0 && (ev == 1 || (ev == 30 && o inside {2, 3})));
         if (t && (v == 0 || v == 4095)) ok = 0;
         ot = (lnk[o] == 0 || (lnk[o] == 2 && ev == pv[o])) ? 0 : (ev == 1 ? t : 1);
         chk(fwd, ok);
         chk(ing, !t && lnk[i] != 1);
         if (ok) chk(rvid, ev);
         if (ok) chk({ins, strp}, {ot && !t, !ot && t});
      end
      @(posedge clk);
   endtask
   task automatic print_verdict;
      if (fails == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      k = $urandom(74);
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(32'h0, 32'h0);
      rd(32'h4, 32'h0);
      chk(grant, 1'b1);
      rd(32'h8, 32'h1);
      frame(0, 1, 1, 30);
      wr(32'h0, 32'h6);
      @(posedge clk);
      chk(gvrp, 1'b1);
      wr(32'h0, 32'h5);
      @(posedge clk);
      chk(gvrp, 1'b0);
      wr(32'h0, 32'h2);
      md = 2;
      frame(0, 1, 0, 0);
      // trunk, hybrid and access ports; the tagged set matches the far switch
      wr(32'h108, 32'h0001_0001);
      wr(32'h10C, 32'h0014_0002);
      wr(32'h110, 32'h0014_0000);
      wr(32'hC, 32'h1);
      wr(32'h10, 32'h801E);
      wr(32'h14, 32'hC);
      wr(32'h104, 32'h0FFF_0000);
      rd(32'h104, 32'h0001_0000);
      wr(32'h104, 32'h0FFE_0000);
      rd(32'h104, 32'h0FFE_0000);
      wr(32'h104, 32'h0001_0000);
      wr(32'hC, 32'h0);
      wr(32'h10, 32'h0);
      rd(32'h10, 32'h8001);
      rd(32'h8, 32'h0001_0002);
      wr(32'h4, 32'h14);
      mport <= 5'h04;
      repeat (2) @(posedge clk);
      chk(grant, 1'b1);
      mport <= 5'h00;
      repeat (2) @(posedge clk);
      chk(grant, 1'b0);
      // trunk port 2 stores vid 1 but has no untagged vid, so vid 1 must not admit it
      wr(32'h4, 32'h1);
      mport <= 5'h02;
      repeat (2) @(posedge clk);
      chk(grant, 1'b0);
      for (k = 0; k < 60; k++) frame($urandom % 5, $urandom % 5, $urandom % 2, vals[$urandom % 5]);
      print_verdict();
   end
   initial begin
      #500us;
      fails++;
      print_verdict();
   end
endmodule
`default_nettype wire
